// >>> adcfmt_chan_fmt.sv
`timescale 1ns/1ns
`default_nettype none
module adcfmt_chan_fmt
  import adcfmt_pkg::*;
(
  input  wire logic [SAMPLE_W-1:0] raw,
  input  wire logic                above_fs,
  input  wire logic                below_fs,
  input  wire adcfmt_cfg_s         cfg,
  input  wire logic                alt_phase,
  output logic      [SAMPLE_W-1:0] word,
  output logic                     overrange_flag
);

  // ----------------------------------------------------------------
  // coding, randomizer, polarity, test override
  // ----------------------------------------------------------------
  always_comb begin
    word           = raw;
    overrange_flag = above_fs | below_fs;
    if (above_fs) begin
      word = '1;
    end else if (below_fs) begin
      word = '0;
    end
    // order matters: coding, then scrambling, then polarity
    if (cfg.twos) begin
      word[SAMPLE_W-1] = ~word[SAMPLE_W-1];
    end
    if (cfg.rand_en) begin
      word[SAMPLE_W-1:1] = word[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){word[0]}};
    end
    if (cfg.abp) begin
      word = word ^ ABP_MASK;
    end
    if (cfg.test_en) begin
      case (cfg.pat)
        PAT_ONES: begin
          word           = '1;
          overrange_flag = 1'b1;
        end
        PAT_ZEROS: begin
          word           = '0;
          overrange_flag = 1'b0;
        end
        PAT_ALT: begin
          word           = {SAMPLE_W{alt_phase}};
          overrange_flag = alt_phase;
        end
        default: begin
          word           = alt_phase ? ~CHECKER_WORD : CHECKER_WORD;
          overrange_flag = ~alt_phase;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> adcfmt_pkg.sv
`default_nettype none
package adcfmt_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W     = 16;
  localparam int unsigned PAIR_W       = SAMPLE_W / 2;
  localparam int unsigned CHANS        = 2;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // one sample period is split into 45 degree steps of one aclk each
  localparam int unsigned PHASE_STEPS  = 8;
  localparam int unsigned CNT_W        = $clog2(PHASE_STEPS);
  localparam int unsigned SAMPLE_PERIOD_NS = CLK_PERIOD_NS * PHASE_STEPS;
  localparam logic [CNT_W-1:0] CNT_LAST     = 3'h7;
  localparam logic [CNT_W-1:0] CNT_HALF_END = 3'h3;

  // ----------------------------------------------------------------
  // register offsets, fields, reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CLOCKING    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_MODE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FORMAT      = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 4'hc;

  localparam int unsigned CLK_INV_BIT   = 0;
  localparam int unsigned CLK_PHASE_LSB = 1;
  localparam int unsigned CLK_DCS_BIT   = 3;
  localparam int unsigned OUT_MODE_LSB  = 0;
  localparam int unsigned OUT_CUR_LSB   = 2;
  localparam int unsigned OUT_TERM_BIT  = 5;
  localparam int unsigned FMT_TWOS_BIT  = 0;
  localparam int unsigned FMT_RAND_BIT  = 1;
  localparam int unsigned FMT_ABP_BIT   = 2;
  localparam int unsigned FMT_TEST_BIT  = 3;
  localparam int unsigned FMT_PAT_LSB   = 4;
  localparam int unsigned STAT_PAR_BIT  = 0;
  localparam int unsigned STAT_MODE_LSB = 1;
  localparam int unsigned STAT_NOPH_BIT = 3;
  localparam int unsigned STAT_CUR_LSB  = 16;

  localparam logic [3:0] CLOCKING_RST    = 4'h0;
  localparam logic [5:0] OUTPUT_MODE_RST = 6'h10;
  localparam logic [5:0] FORMAT_RST      = 6'h00;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FULL_CMOS = 2'b00,
    MODE_DDR_CMOS  = 2'b01,
    MODE_DDR_LVDS  = 2'b10,
    MODE_RSVD      = 2'b11
  } adcfmt_mode_e;

  typedef enum logic [1:0] {
    PAT_ONES    = 2'b00,
    PAT_ZEROS   = 2'b01,
    PAT_ALT     = 2'b10,
    PAT_CHECKER = 2'b11
  } adcfmt_pat_e;

  localparam logic [2:0] CUR_DEFAULT = 3'h4;
  localparam logic [2:0] CUR_RSVD    = 3'h7;
  // driver current in units of 10 uA, codes 0..6
  localparam logic [9:0] CUR_10UA [0:6] = '{10'h0af, 10'h0d2, 10'h0fa, 10'h12c, 10'h15e, 10'h190, 10'h1c2};

  localparam logic [SAMPLE_W-1:0] ABP_MASK     = 16'haaaa;
  localparam logic [SAMPLE_W-1:0] CHECKER_WORD = 16'h5555;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        twos;
    logic        rand_en;
    logic        abp;
    logic        test_en;
    adcfmt_pat_e pat;
  } adcfmt_cfg_s;

  // pair index 0 is chan1_pair_bits_lowest (bits 0/1), index 7 the highest (14/15)
  typedef struct packed {
    logic                fwd_clock_pos;
    logic                fwd_clock_neg;
    logic                chan1_overrange_out;
    logic                chan2_overrange_out;
    logic                shared_overrange_out;
    logic [SAMPLE_W-1:0] chan1_word;
    logic [SAMPLE_W-1:0] chan2_word;
    logic [PAIR_W-1:0]   chan1_pair;
    logic [PAIR_W-1:0]   chan2_pair;
    logic                lvds_mode;
  } adcfmt_pins_s;

endpackage
`default_nettype wire

// >>> adcfmt_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module adcfmt_rx_model
  import adcfmt_pkg::*;
(
  input  wire adcfmt_pins_s        pins,
  input  wire logic                rand_en,
  input  wire logic                abp,
  output logic      [SAMPLE_W-1:0] rec
);
  logic [SAMPLE_W-1:0] w;
  initial rec = '0;
  // capture on the rising edge, undo polarity before the randomizer
  always @(posedge pins.fwd_clock_pos) begin
    w = pins.chan1_word ^ (abp ? ABP_MASK : 16'h0000);
    rec <= w ^ (rand_en ? {{15{w[0]}}, 1'b0} : 16'h0000);
  end
endmodule
`default_nettype wire

// >>> adcfmt_top.sv
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module adcfmt_top
  import adcfmt_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [ADDR_W-1:0]            awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic      [1:0]                   bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [ADDR_W-1:0]            araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic      [31:0]                  rdata,
  output logic      [1:0]                   rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  input  wire logic [CHANS-1:0][SAMPLE_W-1:0] chan_sample,
  input  wire logic [CHANS-1:0]             chan_above_fs,
  input  wire logic [CHANS-1:0]             chan_below_fs,
  input  wire logic                         par_mode_pin,
  input  wire logic                         strap_lvds_pin,
  input  wire logic                         strap_dcs_pin,
  output logic                              sample_take,
  output adcfmt_pins_s                      pins,
  output logic                              lvds_term_en,
  output logic      [9:0]                   lvds_current_10ua,
  output logic                              dcs_enable
);

  // ----------------------------------------------------------------
  // strap synchronisers
  // ----------------------------------------------------------------
  logic [2:0] strap_meta_q;
  logic [2:0] strap_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_meta_q <= 3'h0;
      strap_q      <= 3'h0;
    end else begin
      strap_meta_q <= {strap_dcs_pin, strap_lvds_pin, par_mode_pin};
      strap_q      <= strap_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite register slave
  // ----------------------------------------------------------------
  logic [3:0]        clk_reg_q;
  logic [5:0]        out_reg_q;
  logic [5:0]        fmt_reg_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_byte_q;
  logic              w_lane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_d;
  logic              rhit_d;
  logic              do_write;
  logic [31:0]       status_word;

  assign awready  = !aw_have_q && !bvalid_q;
  assign wready   = !w_have_q && !bvalid_q;
  assign arready  = !rvalid_q;
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign rvalid   = rvalid_q;
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // reserved mode and current codes are dropped so the drivers never see them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_reg_q <= CLOCKING_RST;
      out_reg_q <= OUTPUT_MODE_RST;
      fmt_reg_q <= FORMAT_RST;
    end else if (do_write && w_lane_q) begin
      if (aw_addr_q == OFS_CLOCKING) begin
        clk_reg_q <= w_byte_q[3:0];
      end else if (aw_addr_q == OFS_OUTPUT_MODE) begin
        if (w_byte_q[OUT_MODE_LSB+:2] != MODE_RSVD) begin
          out_reg_q[OUT_MODE_LSB+:2] <= w_byte_q[OUT_MODE_LSB+:2];
        end
        if (w_byte_q[OUT_CUR_LSB+:3] != CUR_RSVD) begin
          out_reg_q[OUT_CUR_LSB+:3] <= w_byte_q[OUT_CUR_LSB+:3];
        end
        out_reg_q[OUT_TERM_BIT] <= w_byte_q[OUT_TERM_BIT];
      end else if (aw_addr_q == OFS_FORMAT) begin
        fmt_reg_q <= w_byte_q[5:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      if (aw_addr_q == OFS_CLOCKING || aw_addr_q == OFS_OUTPUT_MODE || aw_addr_q == OFS_FORMAT) begin
        bresp_q <= RESP_OKAY;
      end else begin
        bresp_q <= RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    rhit_d  = 1'b1;
    if (araddr == OFS_CLOCKING) begin
      rdata_d[3:0] = clk_reg_q;
    end else if (araddr == OFS_OUTPUT_MODE) begin
      rdata_d[5:0] = out_reg_q;
    end else if (araddr == OFS_FORMAT) begin
      rdata_d[5:0] = fmt_reg_q;
    end else if (araddr == OFS_STATUS) begin
      rdata_d = status_word;
    end else begin
      rhit_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdata_d;
      rresp_q  <= rhit_d ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // effective configuration
  // ----------------------------------------------------------------
  logic         par_mode;
  adcfmt_mode_e eff_mode;
  logic [2:0]   eff_cur;
  logic         eff_term;
  logic         eff_dcs;
  logic         eff_inv;
  logic [1:0]   eff_phase;
  adcfmt_cfg_s  eff_cfg;
  logic         ddr_mode;

  assign par_mode  = strap_q[0];
  // straps reach only full-rate cmos and ddr lvds
  assign eff_mode  = par_mode ? (strap_q[1] ? MODE_DDR_LVDS : MODE_FULL_CMOS)
                              : adcfmt_mode_e'(out_reg_q[OUT_MODE_LSB+:2]);
  assign eff_cur   = par_mode ? CUR_DEFAULT : out_reg_q[OUT_CUR_LSB+:3];
  assign eff_term  = par_mode ? 1'b0 : out_reg_q[OUT_TERM_BIT];
  assign eff_dcs   = par_mode ? strap_q[2] : clk_reg_q[CLK_DCS_BIT];
  assign eff_inv   = par_mode ? 1'b0 : clk_reg_q[CLK_INV_BIT];
  // shift is only honoured with the stabilizer on; software must set both
  assign eff_phase = (eff_dcs && !par_mode) ? clk_reg_q[CLK_PHASE_LSB+:2] : 2'h0;
  assign eff_cfg   = par_mode ? adcfmt_cfg_s'(6'h00) : adcfmt_cfg_s'({fmt_reg_q[FMT_TWOS_BIT],
                     fmt_reg_q[FMT_RAND_BIT], fmt_reg_q[FMT_ABP_BIT], fmt_reg_q[FMT_TEST_BIT],
                     fmt_reg_q[FMT_PAT_LSB+:2]});
  assign ddr_mode  = (eff_mode == MODE_DDR_CMOS) || (eff_mode == MODE_DDR_LVDS);

  assign status_word = {6'h0, lvds_current_10ua, 12'h0, (clk_reg_q[CLK_PHASE_LSB+:2] != 2'h0) && !eff_dcs,
                        eff_mode, par_mode};

  // ----------------------------------------------------------------
  // sample timing and formatting
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]                 cnt_q;
  logic                             alt_q;
  logic                             tick;
  logic [CHANS-1:0][SAMPLE_W-1:0]   fmt_d;
  logic [CHANS-1:0]                 ovr_d;
  logic [CHANS-1:0][SAMPLE_W-1:0]   fmt_q;
  logic [CHANS-1:0]                 ovr_q;
  logic [CHANS-1:0][PAIR_W-1:0]     even_d;
  logic [CHANS-1:0][PAIR_W-1:0]     odd_q;

  assign tick        = (cnt_q == CNT_LAST);
  assign sample_take = tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      alt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      if (tick) begin
        alt_q <= ~alt_q;
      end
    end
  end

  for (genvar c = 0; c < CHANS; c++) begin : g_chan
    adcfmt_chan_fmt u_fmt (
      .raw            (chan_sample[c]),
      .above_fs       (chan_above_fs[c]),
      .below_fs       (chan_below_fs[c]),
      .cfg            (eff_cfg),
      .alt_phase      (alt_q),
      .word           (fmt_d[c]),
      .overrange_flag (ovr_d[c])
    );
    for (genvar i = 0; i < PAIR_W; i++) begin : g_pair
      assign even_d[c][i] = fmt_d[c][2*i];
      assign odd_q[c][i]  = fmt_q[c][2*i+1];
    end
  end

  // flag and word share one register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_q <= '0;
      ovr_q <= '0;
    end else if (tick) begin
      fmt_q <= fmt_d;
      ovr_q <= ovr_d;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] clk_idx;
  logic             clk_lvl;

  assign cnt_nxt = cnt_q + 3'h1;
  assign clk_idx = cnt_nxt - {1'b0, eff_phase};
  assign clk_lvl = clk_idx[CNT_W-1] ^ eff_inv;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins               <= '0;
      // legs stay complementary even in reset
      pins.fwd_clock_neg <= 1'b1;
    end else begin
      pins.fwd_clock_pos <= clk_lvl;
      pins.fwd_clock_neg <= ~clk_lvl;
      pins.lvds_mode     <= (eff_mode == MODE_DDR_LVDS);
      if (tick) begin
        pins.chan1_word          <= ddr_mode ? '0 : fmt_d[0];
        pins.chan2_word          <= ddr_mode ? '0 : fmt_d[1];
        pins.chan1_overrange_out <= ddr_mode ? 1'b0 : ovr_d[0];
        pins.chan2_overrange_out <= ddr_mode ? 1'b0 : ovr_d[1];
        pins.chan1_pair          <= ddr_mode ? even_d[0] : '0;
        pins.chan2_pair          <= ddr_mode ? even_d[1] : '0;
        pins.shared_overrange_out <= ddr_mode ? ovr_d[0] : 1'b0;
      end else if (cnt_q == CNT_HALF_END) begin
        pins.chan1_pair          <= ddr_mode ? odd_q[0] : '0;
        pins.chan2_pair          <= ddr_mode ? odd_q[1] : '0;
        pins.shared_overrange_out <= ddr_mode ? ovr_q[1] : 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvds_current_10ua <= CUR_10UA[CUR_DEFAULT];
      lvds_term_en      <= 1'b0;
      dcs_enable        <= 1'b0;
    end else begin
      lvds_current_10ua <= eff_term ? {CUR_10UA[eff_cur][8:0], 1'b0} : CUR_10UA[eff_cur];
      lvds_term_en      <= eff_term;
      dcs_enable        <= eff_dcs;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [12:0] cfg_vec;
  logic [12:0] cfg_prev_q;
  logic [3:0]  cfg_age_q;
  logic        steady;

  assign cfg_vec = {eff_mode, eff_cur, eff_term, eff_dcs, eff_inv, eff_phase, eff_cfg.test_en, eff_cfg.twos,
                    eff_cfg.rand_en};
  assign steady  = (cfg_age_q == 4'hf);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_prev_q <= '0;
      cfg_age_q  <= 4'h0;
    end else begin
      cfg_prev_q <= cfg_vec;
      if (cfg_vec != cfg_prev_q) begin
        cfg_age_q <= 4'h0;
      end else if (!steady) begin
        cfg_age_q <= cfg_age_q + 4'h1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_clk_fall;
    !pins.fwd_clock_pos && $past(pins.fwd_clock_pos);
  endsequence
  sequence s_clk_rise;
    pins.fwd_clock_pos && !$past(pins.fwd_clock_pos);
  endsequence

  a_ddr_even_half: assert property (steady && ddr_mode && cnt_q == 3'h1 |-> pins.chan1_pair ==
    {fmt_q[0][14], fmt_q[0][12], fmt_q[0][10], fmt_q[0][8], fmt_q[0][6], fmt_q[0][4], fmt_q[0][2], fmt_q[0][0]})
    else $error("even bits not on pair pins in first half");
  a_ddr_odd_half: assert property (steady && ddr_mode && cnt_q == 3'h5 |-> pins.chan2_pair == odd_q[1])
    else $error("odd bits not on pair pins in second half");
  a_shared_ovr_mux: assert property (steady && ddr_mode && tick |=> pins.shared_overrange_out == $past(ovr_d[0])
    ##4 pins.shared_overrange_out == ovr_q[1]) else $error("shared overrange not muxed ch1 then ch2");
  a_full_ovr_pins: assert property (steady && eff_mode == MODE_FULL_CMOS && tick |=>
    pins.chan2_overrange_out == $past(ovr_d[1]) && !pins.shared_overrange_out)
    else $error("full rate overrange pin wrong");
  a_ovr_full_scale: assert property (tick && chan_above_fs[1] && !eff_cfg.test_en && !eff_cfg.rand_en &&
    !eff_cfg.abp && !ddr_mode |=> pins.chan2_overrange_out && pins.chan2_word == {!$past(eff_cfg.twos), 15'h7fff})
    else $error("overrange not forced to full scale");
  a_full_clk_fall: assert property (steady && eff_mode == MODE_FULL_CMOS && eff_phase == 2'h0 && !eff_inv &&
    cnt_q == 3'h0 |-> s_clk_fall) else $error("full rate data not aligned to falling clock");
  a_ddr_clk_edges: assert property (steady && ddr_mode && eff_phase == 2'h0 && !eff_inv && cnt_q == 3'h0 |->
    s_clk_fall ##4 s_clk_rise) else $error("ddr data not aligned to both clock edges");
  a_phase_delay: assert property (steady && !eff_inv && cnt_q == {1'b0, eff_phase} |-> s_clk_fall)
    else $error("forwarded clock phase wrong");
  a_clk_legs: assert property (pins.fwd_clock_neg == !pins.fwd_clock_pos)
    else $error("clock legs not complementary");
  a_lvds_current: assert property (steady && eff_term |-> lvds_current_10ua == {CUR_10UA[eff_cur][8:0], 1'b0})
    else $error("terminated current not doubled");
  a_strap_no_ddr_cmos: assert property (par_mode |-> eff_mode != MODE_DDR_CMOS)
    else $error("strap mode reached ddr cmos");

endmodule
`default_nettype wire

// >>> dual_adc_output_formatter_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dual_adc_output_formatter_tb_top
  import adcfmt_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic take, term, dcs, rnd, abp;
  logic par, slvds, sdcs;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [CHANS-1:0][SAMPLE_W-1:0] smp;
  logic [CHANS-1:0] above, below;
  logic [9:0] cur;
  logic [15:0] rec;
  logic [7:0] ev, od;
  adcfmt_pins_s pins;
  int fails, n_checks, cyc;

  adcfmt_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .chan_sample(smp), .chan_above_fs(above), .chan_below_fs(below),
    .par_mode_pin(par), .strap_lvds_pin(slvds), .strap_dcs_pin(sdcs), .sample_take(take), .pins(pins),
    .lvds_term_en(term), .lvds_current_10ua(cur), .dcs_enable(dcs));
  adcfmt_rx_model rx (.pins(pins), .rand_en(rnd), .abp(abp), .rec(rec));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // raised only here so back-to-back writes never touch bready twice in one step
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // two takes: the first may still carry the old setting
  task automatic smp_wait();
    repeat (2) @(posedge aclk iff take === 1'b1);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] fmt(input logic [15:0] v, input logic r, input logic p);
    fmt = r ? v ^ {{15{v[0]}}, 1'b0} : v;
    fmt = p ? fmt ^ ABP_MASK : fmt;
  endfunction

  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rnd, abp, above, below, par, slvds, sdcs} = '0;
    {awaddr, araddr, wdata, smp} = '0;
    for (int i = 0; i < 8; i++) begin
      ev[i] = 1'(16'h1235 >> (2 * i));
      od[i] = 1'(16'h1235 >> (2 * i + 1));
    end
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(OFS_OUTPUT_MODE);
    chk("out_mode", 32'h10, rd);
    chk("cur_rst", 10'h15e, cur);
    wr(OFS_OUTPUT_MODE, 32'h38);
    // current is registered after the mode register; long enough for the settled check
    repeat (20) @(posedge aclk);
    chk("cur_term", 10'h384, cur);
    chk("term", 1'b1, term);
    wr(OFS_OUTPUT_MODE, 32'h00);
    @(posedge aclk);
    chk("cur_min", 10'h0af, cur);
    wr(4'h2, 32'h0);
    chk("unmapped", RESP_SLVERR, resp);
    smp[0] <= 16'h1235;
    for (int k = 0; k < 4; k++) begin
      rnd = k[0];
      abp = k[1];
      wr(OFS_FORMAT, k << 1);
      smp_wait();
      chk("word", fmt(16'h1235, rnd, abp), pins.chan1_word);
      repeat (5) @(posedge aclk);
      chk("rx", 16'h1235, rec);
    end
    wr(OFS_FORMAT, 32'h1);
    smp[0] <= 16'h8000;
    above <= 2'b10;
    smp_wait();
    chk("twos", 16'h0000, pins.chan1_word);
    chk("fs", 16'h7fff, pins.chan2_word);
    chk("of", 2'b01, {pins.chan1_overrange_out, pins.chan2_overrange_out});
    wr(OFS_FORMAT, 32'h0b);
    smp_wait();
    chk("pat", 32'hffff, pins.chan1_word);
    chk("pat_of", 2'b11, {pins.chan1_overrange_out, pins.chan2_overrange_out});
    wr(OFS_FORMAT, 32'h0);
    wr(OFS_OUTPUT_MODE, 32'h11);
    smp[0] <= 16'h1235;
    above <= 2'b00;
    below <= 2'b10;
    smp_wait();
    chk("even", ev, pins.chan1_pair);
    chk("sh1", 2'b00, {pins.shared_overrange_out, pins.fwd_clock_pos});
    repeat (4) @(posedge aclk);
    #1;
    chk("odd", od, pins.chan1_pair);
    chk("sh2", 2'b11, {pins.shared_overrange_out, pins.fwd_clock_pos});
    wr(OFS_CLOCKING, 32'h0a);
    smp_wait();
    chk("ph", 2'b10, {pins.fwd_clock_pos, pins.fwd_clock_neg});
    chk("dcs", 1'b1, dcs);
    @(posedge aclk);
    #1;
    chk("ph1", 1'b0, pins.fwd_clock_pos);
    wr(OFS_CLOCKING, 32'h0b);
    smp_wait();
    chk("inv", 1'b0, pins.fwd_clock_pos);
    wr(OFS_OUTPUT_MODE, 32'h12);
    smp_wait();
    chk("lvds", 1'b1, pins.lvds_mode);
    rdr(OFS_STATUS);
    chk("status", 32'h015e0004, rd);
    rdr(4'h2);
    chk("rd_unmapped", RESP_SLVERR, resp);
    wr(OFS_OUTPUT_MODE, 32'h11);
    {par, slvds, sdcs} <= 3'h6;
    smp_wait();
    chk("strap", 2'b10, {pins.lvds_mode, dcs});
    stop_test();
  end
endmodule
`default_nettype wire
